// file: rtl/ocm_pkg.sv
// package: constants, types and decoders for the oscillator request block
package ocm_pkg;
    // register data width
    localparam int OCM_DATA_W = 8;
    // register offsets (word index on the plain register port)
    localparam logic [7:0] OCM_REQ_OFS  = 8'h00;
    localparam logic [7:0] OCM_FRQ_OFS  = 8'h01;
    localparam logic [7:0] OCM_STAT_OFS = 8'h02;
    // oscillator index order used on the vector ports
    localparam int OCM_NUM_OSC  = 5;
    localparam int OCM_OSC_EXT  = 0;
    localparam int OCM_OSC_FAST = 1;
    localparam int OCM_OSC_SLOW = 2;
    localparam int OCM_OSC_SEC  = 3;
    localparam int OCM_OSC_AUX  = 4;
    // bit positions in request and ready status registers
    localparam int OCM_EXT_BIT  = 7;
    localparam int OCM_FAST_BIT = 6;
    localparam int OCM_SLOW_BIT = 4;
    localparam int OCM_SEC_BIT  = 3;
    localparam int OCM_AUX_BIT  = 2;
    // implemented-bit masks
    localparam logic [7:0] OCM_REQ_MASK  = 8'hdc;
    localparam logic [7:0] OCM_FRQ_MASK  = 8'h0f;
    localparam logic [7:0] OCM_STAT_MASK = 8'hdc;
    // reset values, same for every reset type
    localparam logic [7:0] OCM_REQ_RST = 8'h00;
    localparam logic [3:0] OCM_FRQ_RST = 4'h6;
    // frequency codes
    localparam logic [3:0] OCM_FRQ_1M   = 4'h0;
    localparam logic [3:0] OCM_FRQ_2M   = 4'h1;
    localparam logic [3:0] OCM_FRQ_RSVD = 4'h2;
    localparam logic [3:0] OCM_FRQ_4M   = 4'h3;
    localparam logic [3:0] OCM_FRQ_8M   = 4'h4;
    localparam logic [3:0] OCM_FRQ_12M  = 4'h5;
    localparam logic [3:0] OCM_FRQ_16M  = 4'h6;
    // clock period and oscillator settle time
    localparam int OCM_CLK_NS     = 40;
    localparam int OCM_SETTLE_NS  = 1000;
    localparam int OCM_SETTLE_CYC =
        (OCM_SETTLE_NS + OCM_CLK_NS - 1) / OCM_CLK_NS;
    // ready tracker states
    typedef enum logic [1:0] {
        OCM_RDY_OFF    = 2'b00,
        OCM_RDY_SETTLE = 2'b01,
        OCM_RDY_ON     = 2'b10
    } ocm_rdy_state_t;

    // register bit of an oscillator index
    function automatic int ocm_bit_pos(input int idx);
        case (idx)
            OCM_OSC_EXT:  return OCM_EXT_BIT;
            OCM_OSC_FAST: return OCM_FAST_BIT;
            OCM_OSC_SLOW: return OCM_SLOW_BIT;
            OCM_OSC_SEC:  return OCM_SEC_BIT;
            default:      return OCM_AUX_BIT;
        endcase
    endfunction

    // nominal frequency in MHz, zero for the reserved code
    function automatic logic [5:0] ocm_freq_mhz(input logic [3:0] code);
        if (code[3]) begin
            return 6'h20;
        end else if (code == OCM_FRQ_1M) begin
            return 6'h01;
        end else if (code == OCM_FRQ_2M) begin
            return 6'h02;
        end else if (code == OCM_FRQ_RSVD) begin
            return 6'h00;
        end else if (code == OCM_FRQ_4M) begin
            return 6'h04;
        end else if (code == OCM_FRQ_8M) begin
            return 6'h08;
        end else if (code == OCM_FRQ_12M) begin
            return 6'h0c;
        end else if (code == OCM_FRQ_16M) begin
            return 6'h10;
        end else begin
            return 6'h20;
        end
    endfunction
endpackage

// file: rtl/ocm_osc_ready.sv
// module: per-oscillator ready tracker with running-pin synchroniser
`timescale 1ns/10ps
module ocm_osc_ready
    import ocm_pkg::*;
#(
    parameter int SETTLE_CYC = OCM_SETTLE_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic running_raw,
    output logic      ready
);
    localparam int CNT_W = $clog2(SETTLE_CYC + 1);

    // refuse a settle time the counter cannot serve
    if (SETTLE_CYC < 1 || SETTLE_CYC > 4096) begin : g_chk
        $error("ocm_osc_ready: SETTLE_CYC out of range");
    end

    // all state of the tracker
    typedef struct packed {
        logic           sync1;
        logic           sync2;
        ocm_rdy_state_t st;
        logic [CNT_W-1:0] cnt;
        logic           ready;
    } ocm_rdy_t;

    ocm_rdy_t cur;       // registered state
    ocm_rdy_t next_cur;  // next state

    // next state: wait for enable and running, settle, then report ready
    always_comb begin
        next_cur = cur;
        next_cur.sync1 = running_raw;
        next_cur.sync2 = cur.sync1;
        case (cur.st)
            OCM_RDY_OFF: begin
                if (enable && cur.sync2) begin
                    next_cur.st  = OCM_RDY_SETTLE;
                    next_cur.cnt = '0;
                end
            end
            OCM_RDY_SETTLE: begin
                if (!enable || !cur.sync2) begin
                    next_cur.st = OCM_RDY_OFF;
                end else if (cur.cnt == CNT_W'(SETTLE_CYC - 1)) begin
                    next_cur.st = OCM_RDY_ON;
                end else begin
                    next_cur.cnt = cur.cnt + CNT_W'(1);
                end
            end
            OCM_RDY_ON: begin
                if (!enable || !cur.sync2) begin
                    next_cur.st = OCM_RDY_OFF;
                end
            end
            default: begin
                next_cur.st = OCM_RDY_OFF;
            end
        endcase
        // ready only in the on state, cleared on the edge after enable drops
        next_cur.ready = (next_cur.st == OCM_RDY_ON);
    end

    // state register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur <= '{1'b0, 1'b0, OCM_RDY_OFF, '0, 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign ready = cur.ready;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // disabled oscillator never reads ready on the next edge
    property p_off_not_ready;
        !enable |=> !ready;
    endproperty
    a_off_not_ready: assert property (p_off_not_ready)
        else $error("ready while oscillator disabled");

    // ready only rises after a full settle while enabled
    property p_ready_after_settle;
        $rose(ready) |-> $past(enable) && $past(cur.st) == OCM_RDY_SETTLE;
    endproperty
    a_ready_after_settle: assert property (p_ready_after_settle)
        else $error("ready rose without settling");
endmodule

// file: rtl/ocm_osc_ctrl.sv
// module: oscillator manual requests, fast oscillator frequency, ready status
//
// Contract
// - fast request forces fast oscillator at chosen frequency
// - fast request clear: demand alone may enable it
// - slow request bit 4 forces slow oscillator
// - secondary request bit 3 forces secondary oscillator
// - secondary request clear: demand may still enable
// - aux request bit 2 forces aux oscillator
// - aux request clear: demand alone may enable it
// - unimplemented bits ignore writes, read zero
// - request bits read/write, reset to zero
// - frequency field bits 3:0, resets to 0110
// - frequency code selects nominal MHz
// - ready bit set only when oscillator ready
`timescale 1ns/10ps
module ocm_osc_ctrl
    import ocm_pkg::*;
#(
    parameter int ADDR_W     = 2,
    parameter int SETTLE_CYC = OCM_SETTLE_CYC
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic [ADDR_W-1:0]      addr,
    input  wire logic [OCM_DATA_W-1:0]  wr_data,
    input  wire logic                   wr_en,
    input  wire logic                   rd_en,
    output logic      [OCM_DATA_W-1:0]  rd_data,
    input  wire logic [OCM_NUM_OSC-1:0] osc_demand,
    input  wire logic [OCM_NUM_OSC-1:0] osc_running,
    output logic      [OCM_NUM_OSC-1:0] osc_enable,
    output logic      [3:0]             fast_osc_freq_code,
    output logic      [5:0]             fast_osc_freq_mhz,
    output logic                        fast_osc_freq_reserved
);
    // the offsets must fit the address port
    if (ADDR_W < 2 || ADDR_W > 8) begin : g_chk
        $error("ocm_osc_ctrl: ADDR_W must be 2 to 8");
    end

    // all state of the block
    typedef struct packed {
        logic [7:0]             req;      // request register
        logic [3:0]             frq;      // frequency field
        logic [7:0]             rd_data;  // read answer
        logic [OCM_NUM_OSC-1:0] osc_en;   // oscillator enables
        logic [5:0]             mhz;      // nominal frequency
        logic                   rsvd;     // reserved code chosen
    } ocm_state_t;

    ocm_state_t cur;       // registered state
    ocm_state_t next_cur;  // next state

    logic [OCM_NUM_OSC-1:0] osc_ready;  // ready flags from trackers
    logic [7:0]             stat_word;  // ready flags at register bits

    // address match helper, used for every register
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0]        ofs);
        return a == ofs[ADDR_W-1:0];
    endfunction

    // one ready tracker per oscillator
    genvar gi;
    generate
        for (gi = 0; gi < OCM_NUM_OSC; gi++) begin : g_rdy
            ocm_osc_ready #(
                .SETTLE_CYC (SETTLE_CYC)
            ) u_rdy (
                .sys_clk     (sys_clk),
                .rst         (rst),
                .enable      (cur.osc_en[gi]),
                .running_raw (osc_running[gi]),
                .ready       (osc_ready[gi])
            );
        end
    endgenerate

    // place ready flags at their status bits, others zero
    always_comb begin
        stat_word = 8'h00;
        for (int i = 0; i < OCM_NUM_OSC; i++) begin
            stat_word[ocm_bit_pos(i)] = osc_ready[i];
        end
    end

    // next state: register writes, read answer, oscillator control
    always_comb begin
        next_cur = cur;
        // writes keep only implemented bits
        if (wr_en) begin
            if (hit(addr, OCM_REQ_OFS)) begin
                next_cur.req = wr_data & OCM_REQ_MASK;
            end else if (hit(addr, OCM_FRQ_OFS)) begin
                next_cur.frq = wr_data[3:0];
            end
        end
        // read answer stands one cycle, zero otherwise
        next_cur.rd_data = 8'h00;
        if (rd_en) begin
            if (hit(addr, OCM_REQ_OFS)) begin
                next_cur.rd_data = cur.req & OCM_REQ_MASK;
            end else if (hit(addr, OCM_FRQ_OFS)) begin
                next_cur.rd_data = {4'h0, cur.frq};
            end else if (hit(addr, OCM_STAT_OFS)) begin
                next_cur.rd_data = stat_word & OCM_STAT_MASK;
            end else begin
                // unmapped address reads zero
                next_cur.rd_data = 8'h00;
            end
        end
        // enable = manual request or another module's demand
        for (int i = 0; i < OCM_NUM_OSC; i++) begin
            next_cur.osc_en[i] =
                cur.req[ocm_bit_pos(i)] | osc_demand[i];
        end
        // fast oscillator frequency follows the field
        next_cur.mhz  = ocm_freq_mhz(cur.frq);
        next_cur.rsvd = (cur.frq == OCM_FRQ_RSVD);
    end

    // state register, same values for every reset type
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur <= '{OCM_REQ_RST, OCM_FRQ_RST, 8'h00, '0,
                     6'h10, 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    // outputs straight from the state register
    assign rd_data                = cur.rd_data;
    assign osc_enable             = cur.osc_en;
    assign fast_osc_freq_code     = cur.frq;
    assign fast_osc_freq_mhz      = cur.mhz;
    assign fast_osc_freq_reserved = cur.rsvd;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // a write to the request register then a read of it
    sequence s_req_wr_rd;
        wr_en && hit(addr, OCM_REQ_OFS)
            ##1 rd_en && hit(addr, OCM_REQ_OFS);
    endsequence

    // a write to the frequency register then a read of it
    sequence s_frq_wr_rd;
        wr_en && hit(addr, OCM_FRQ_OFS)
            ##1 rd_en && hit(addr, OCM_FRQ_OFS);
    endsequence

    // fast request held: enable on, frequency kept unless rewritten
    property p_fast_forced;
        cur.req[OCM_FAST_BIT] && !(wr_en && hit(addr, OCM_FRQ_OFS)) |=>
            osc_enable[OCM_OSC_FAST]
            && fast_osc_freq_code == $past(cur.frq);
    endproperty
    a_fast_forced: assert property (p_fast_forced)
        else $error("fast oscillator not forced on");

    // fast request clear: enable equals demand
    property p_fast_demand;
        !cur.req[OCM_FAST_BIT] |=>
            osc_enable[OCM_OSC_FAST] == $past(osc_demand[OCM_OSC_FAST]);
    endproperty
    a_fast_demand: assert property (p_fast_demand)
        else $error("fast oscillator enable does not follow demand");

    // slow request forces slow oscillator
    property p_slow_forced;
        cur.req[OCM_SLOW_BIT] |=> osc_enable[OCM_OSC_SLOW];
    endproperty
    a_slow_forced: assert property (p_slow_forced)
        else $error("slow oscillator not forced on");

    // secondary request forces secondary oscillator
    property p_sec_forced;
        cur.req[OCM_SEC_BIT] |=> osc_enable[OCM_OSC_SEC];
    endproperty
    a_sec_forced: assert property (p_sec_forced)
        else $error("secondary oscillator not forced on");

    // secondary request clear: demand alone enables it
    property p_sec_demand;
        !cur.req[OCM_SEC_BIT] && osc_demand[OCM_OSC_SEC] |=>
            osc_enable[OCM_OSC_SEC];
    endproperty
    a_sec_demand: assert property (p_sec_demand)
        else $error("secondary oscillator demand ignored");

    // aux request forces aux oscillator
    property p_aux_forced;
        cur.req[OCM_AUX_BIT] |=> osc_enable[OCM_OSC_AUX];
    endproperty
    a_aux_forced: assert property (p_aux_forced)
        else $error("aux oscillator not forced on");

    // aux request clear and no demand: aux is off
    property p_aux_idle;
        !cur.req[OCM_AUX_BIT] && !osc_demand[OCM_OSC_AUX] |=>
            !osc_enable[OCM_OSC_AUX];
    endproperty
    a_aux_idle: assert property (p_aux_idle)
        else $error("aux oscillator forced without request");

    // request register never reads unimplemented bits
    property p_req_unimpl;
        rd_en && hit(addr, OCM_REQ_OFS) |=>
            (rd_data & ~OCM_REQ_MASK) == 8'h00;
    endproperty
    a_req_unimpl: assert property (p_req_unimpl)
        else $error("unimplemented request bit read as one");

    // request register reads back the written implemented bits
    property p_req_rw;
        s_req_wr_rd |=> rd_data == ($past(wr_data, 2) & OCM_REQ_MASK);
    endproperty
    a_req_rw: assert property (p_req_rw)
        else $error("request register read-back mismatch");

    // frequency register reads back field with upper nibble zero
    property p_frq_rw;
        s_frq_wr_rd |=> rd_data == {4'h0, $past(wr_data[3:0], 2)};
    endproperty
    a_frq_rw: assert property (p_frq_rw)
        else $error("frequency register read-back mismatch");

    // nominal frequency follows the field one cycle later
    property p_freq_map;
        ##1 fast_osc_freq_mhz == ocm_freq_mhz($past(cur.frq));
    endproperty
    a_freq_map: assert property (p_freq_map)
        else $error("nominal frequency does not match code");

    // status read shows each ready flag at its bit
    property p_stat_read;
        rd_en && hit(addr, OCM_STAT_OFS) |=>
            rd_data == $past(stat_word & OCM_STAT_MASK);
    endproperty
    a_stat_read: assert property (p_stat_read)
        else $error("ready status read mismatch");

    // external request forces external oscillator
    property p_ext_forced;
        cur.req[OCM_EXT_BIT] |=> osc_enable[OCM_OSC_EXT];
    endproperty
    a_ext_forced: assert property (p_ext_forced)
        else $error("external oscillator not forced on");

    // request register only changes on a write to it
    property p_req_hold;
        !(wr_en && hit(addr, OCM_REQ_OFS)) |=> $stable(cur.req);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request register changed without a write");

    // frequency field only changes on a write to it
    property p_frq_hold;
        !(wr_en && hit(addr, OCM_FRQ_OFS)) |=> $stable(cur.frq);
    endproperty
    a_frq_hold: assert property (p_frq_hold)
        else $error("frequency field changed without a write");

    // frequency register read keeps the upper nibble zero
    property p_frq_unimpl;
        rd_en && hit(addr, OCM_FRQ_OFS) |=> rd_data[7:4] == 4'h0;
    endproperty
    a_frq_unimpl: assert property (p_frq_unimpl)
        else $error("frequency register upper bits read as one");

    // status read never shows bits without an oscillator
    property p_stat_unimpl;
        rd_en && hit(addr, OCM_STAT_OFS) |=>
            (rd_data & ~OCM_STAT_MASK) == 8'h00;
    endproperty
    a_stat_unimpl: assert property (p_stat_unimpl)
        else $error("unimplemented status bit read as one");

    // unmapped reads and idle cycles answer zero
    property p_rd_zero;
        !rd_en || !(hit(addr, OCM_REQ_OFS) || hit(addr, OCM_FRQ_OFS)
            || hit(addr, OCM_STAT_OFS)) |=> rd_data == 8'h00;
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("read answer not zero");

    // slow request clear: demand alone enables it
    property p_slow_demand;
        !cur.req[OCM_SLOW_BIT] && osc_demand[OCM_OSC_SLOW] |=>
            osc_enable[OCM_OSC_SLOW];
    endproperty
    a_slow_demand: assert property (p_slow_demand)
        else $error("slow oscillator demand ignored");

    // aux request clear: demand alone enables it
    property p_aux_demand;
        !cur.req[OCM_AUX_BIT] && osc_demand[OCM_OSC_AUX] |=>
            osc_enable[OCM_OSC_AUX];
    endproperty
    a_aux_demand: assert property (p_aux_demand)
        else $error("aux oscillator demand ignored");

    // external request clear: demand alone enables it
    property p_ext_demand;
        !cur.req[OCM_EXT_BIT] && osc_demand[OCM_OSC_EXT] |=>
            osc_enable[OCM_OSC_EXT];
    endproperty
    a_ext_demand: assert property (p_ext_demand)
        else $error("external oscillator demand ignored");

    // any code with the top bit set gives 32 MHz
    property p_freq_top;
        cur.frq[3] |=> fast_osc_freq_mhz == 6'h20;
    endproperty
    a_freq_top: assert property (p_freq_top)
        else $error("top frequency codes not at 32 MHz");

    // reserved code raises the flag and reports no frequency
    property p_freq_rsvd;
        cur.frq == OCM_FRQ_RSVD |=>
            fast_osc_freq_reserved && fast_osc_freq_mhz == 6'h00;
    endproperty
    a_freq_rsvd: assert property (p_freq_rsvd)
        else $error("reserved frequency code not flagged");
endmodule

// file: bench/tb.sv
// testbench: self-checking bench for the oscillator request block
`timescale 1ns/10ps
module tb
    import ocm_pkg::*;
;
    localparam int SETTLE = 2;     // shortened settle count for the run
    localparam int LIMIT  = 20000; // cycle ceiling before the run is cut
    logic       sys_clk;           // 25 MHz system clock
    logic       rst;               // asynchronous reset, active high
    logic [1:0] addr;              // register index
    logic [7:0] wr_data;           // write data
    logic       wr_en;             // write strobe
    logic       rd_en;             // read strobe
    logic [7:0] rd_data;           // read answer
    logic [4:0] osc_demand;        // demand from other modules
    logic [4:0] osc_running;       // raw running indications
    logic [4:0] osc_enable;        // oscillator enables
    logic [3:0] fast_osc_freq_code; // frequency field copy
    logic [5:0] fast_osc_freq_mhz;  // nominal frequency
    logic       fast_osc_freq_reserved; // reserved code flag
    int         num_errors;        // mismatches seen
    int         n_checks;          // comparisons made
    int         cyc;               // cycle counter for the timeout
    int         m_req;             // model of the request register
    int         m_frq;             // model of the frequency field
    int         pos [5];           // register bit of each oscillator
    logic [31:0] r;                // random draw
    logic [31:0] d;                // random draw

    // device under test
    ocm_osc_ctrl #(.ADDR_W(2), .SETTLE_CYC(SETTLE)) ocm_osc_ctrl_inst (
        .sys_clk                (sys_clk),
        .rst                    (rst),
        .addr                   (addr),
        .wr_data                (wr_data),
        .wr_en                  (wr_en),
        .rd_en                  (rd_en),
        .rd_data                (rd_data),
        .osc_demand             (osc_demand),
        .osc_running            (osc_running),
        .osc_enable             (osc_enable),
        .fast_osc_freq_code     (fast_osc_freq_code),
        .fast_osc_freq_mhz      (fast_osc_freq_mhz),
        .fast_osc_freq_reserved (fast_osc_freq_reserved)
    );

    // clock generator
    always #20 sys_clk = ~sys_clk;

    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            num_errors++;
            wrap_up();
        end
    end

    // verdict and end of run
    task automatic wrap_up();
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one comparison
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    // wait n edges, then let their updates land
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // one-cycle register write, model follows the masks
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        addr    <= a;
        wr_data <= v;
        wr_en   <= 1'b1;
        @(posedge sys_clk);
        wr_en   <= 1'b0;
        if (a == 2'h0) m_req = v & 8'hdc;
        if (a == 2'h1) m_frq = v & 8'h0f;
    endtask

    // read, check the answer cycle and the return to zero after it
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        chk("rd_data", e, rd_data);
        tick(1);
        chk("rd_data idle", 8'h00, rd_data);
    endtask

    // write, then read back in the very next cycle
    task automatic wr_rd_chk(input logic [1:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        addr    <= a;
        wr_data <= v;
        wr_en   <= 1'b1;
        @(posedge sys_clk);
        wr_en   <= 1'b0;
        rd_en   <= 1'b1;
        @(posedge sys_clk);
        rd_en   <= 1'b0;
        #1;
        if (a == 2'h0) m_req = v & 8'hdc;
        if (a == 2'h1) m_frq = v & 8'h0f;
        chk("rd_data b2b", (a == 2'h0) ? 8'(m_req) : 8'(m_frq), rd_data);
    endtask

    // expected enables: request bit or demand
    function automatic logic [4:0] exp_en(input int q, input logic [4:0] dm);
        logic [4:0] e;
        for (int i = 0; i < 5; i++) e[i] = q[pos[i]] | dm[i];
        return e;
    endfunction

    // expected nominal MHz of a frequency code
    function automatic logic [5:0] exp_mhz(input int c);
        case (c)
            0:       return 6'h01;
            1:       return 6'h02;
            2:       return 6'h00;
            3:       return 6'h04;
            4:       return 6'h08;
            5:       return 6'h0c;
            6:       return 6'h10;
            default: return 6'h20;
        endcase
    endfunction

    // check the frequency outputs against the model
    task automatic chk_frq();
        chk("freq_code", 8'(m_frq), {4'h0, fast_osc_freq_code});
        chk("freq_mhz", {2'h0, exp_mhz(m_frq)},
            {2'h0, fast_osc_freq_mhz});
        chk("freq_rsvd", {7'h0, m_frq == 2},
            {7'h0, fast_osc_freq_reserved});
    endtask

    // main sequence
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        addr = 2'h0;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        osc_demand = 5'h00;
        osc_running = 5'h00;
        num_errors = 0;
        n_checks = 0;
        cyc = 0;
        m_req = 0;
        m_frq = 6;
        pos = '{OCM_EXT_BIT, OCM_FAST_BIT, OCM_SLOW_BIT, OCM_SEC_BIT,
                OCM_AUX_BIT};
        void'($urandom(32'h13e5));
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        tick(1);
        // reset values and unmapped place
        rd_chk(2'h0, 8'h00);
        rd_chk(2'h1, 8'h06);
        rd_chk(2'h3, 8'h00);
        chk_frq();
        // unimplemented bits drop, status and unmapped writes ignored
        wr(2'h0, 8'hff);
        wr(2'h1, 8'hff);
        wr(2'h2, 8'hff);
        wr(2'h3, 8'hff);
        rd_chk(2'h0, 8'hdc);
        rd_chk(2'h1, 8'h0f);
        rd_chk(2'h2, 8'h00);
        // every frequency code
        for (int c = 0; c < 16; c++) begin
            wr_rd_chk(2'h1, 8'(c) | 8'hf0);
            tick(2);
            chk_frq();
            rd_chk(2'h1, 8'(m_frq));
        end
        // each oscillator: forced by request, by demand, or off
        for (int i = 0; i < 5; i++) begin
            for (int k = 0; k < 3; k++) begin
                wr(2'h0, (k == 0) ? (8'h01 << pos[i]) : 8'h00);
                @(posedge sys_clk);
                osc_demand <= (k == 1) ? (5'h01 << i) : 5'h00;
                tick(3);
                chk("osc_enable", {3'h0, exp_en(m_req, osc_demand)},
                    {3'h0, osc_enable});
            end
        end
        // random requests against random demand
        for (int n = 0; n < 40; n++) begin
            r = $urandom;
            d = $urandom;
            wr_rd_chk(2'h0, r[7:0]);
            @(posedge sys_clk);
            osc_demand  <= d[4:0];
            osc_running <= d[9:5];
            tick(3);
            chk("osc_enable", {3'h0, exp_en(m_req, osc_demand)},
                {3'h0, osc_enable});
            rd_chk(2'h0, 8'(m_req));
        end
        // ready status: off, not yet ready, ready, lost
        wr(2'h0, 8'h00);
        @(posedge sys_clk);
        osc_demand  <= 5'h00;
        osc_running <= 5'h1f;
        tick(12);
        rd_chk(2'h2, 8'h00);
        wr(2'h0, 8'h40);
        rd_chk(2'h2, 8'h00);
        tick(SETTLE + 12);
        rd_chk(2'h2, 8'h40);
        wr(2'h0, 8'hdc);
        tick(SETTLE + 12);
        rd_chk(2'h2, 8'hdc);
        @(posedge sys_clk);
        osc_demand <= 5'h05;
        wr(2'h0, 8'h00);
        tick(SETTLE + 12);
        rd_chk(2'h2, 8'h90);
        @(posedge sys_clk);
        osc_running <= 5'h00;
        tick(8);
        rd_chk(2'h2, 8'h00);
        // reset in mid-run restores every value
        wr(2'h0, 8'hdc);
        wr(2'h1, 8'h02);
        @(posedge sys_clk);
        osc_demand <= 5'h00;
        rst <= 1'b1;
        tick(2);
        m_req = 0;
        m_frq = 6;
        chk("osc_enable rst", 8'h00, {3'h0, osc_enable});
        chk_frq();
        @(posedge sys_clk);
        rst <= 1'b0;
        tick(1);
        rd_chk(2'h0, 8'h00);
        rd_chk(2'h1, 8'h06);
        wrap_up();
    end
endmodule
